// [bssp_pkg.sv]
// Constants, register map and types of the buffered serial port
package bssp_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int FS_HZ = 32768;
  // Half period of fs/2^5 in clk cycles
  localparam int LS_HALF_CYC = CLK_HZ / (FS_HZ / 32) / 2;
  // Half period of fc/2^13 in clk cycles
  localparam logic [15:0] SLOW_HALF_CYC = 16'h1000;
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_OPTION = 8'h0c;
  localparam logic [2:0] BUF_PAGE = 3'h1;
  localparam int C1_RUN = 7;
  localparam int C1_ABORT = 6;
  localparam int C1_MODE = 3;
  localparam int C1_SCK = 0;
  localparam int C2_WAIT = 3;
  localparam int C2_COUNT = 0;
  localparam int ST_XFER = 7;
  localparam int ST_SHIFT = 6;
  localparam int OPT_TAP = 0;
  localparam int OPT_LOW = 1;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [2:0] SCK_RST = 3'h0;
  localparam logic [2:0] MODE_TX8 = 3'h0;
  localparam logic [2:0] MODE_TX4 = 3'h2;
  localparam logic [2:0] MODE_TRX8 = 3'h4;
  localparam logic [2:0] MODE_RX8 = 3'h5;
  localparam logic [2:0] MODE_RX4 = 3'h6;
  localparam logic [2:0] SCK_SLOW = 3'h0;
  localparam logic [2:0] SCK_UNUSED = 3'h6;
  localparam logic [2:0] SCK_EXT = 3'h7;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [2:0] LAST_BIT4 = 3'h3;
  // Gap length in half ticks: extra word times of 8 bits each
  localparam logic [7:0] GAP_W1 = 8'h10;
  localparam logic [7:0] GAP_W2 = 8'h30;
  localparam logic [7:0] GAP_W3 = 8'h70;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_GAP = 4'b0100,
    ST_WAIT = 4'b1000
  } bssp_state_t;
endpackage : bssp_pkg

// [bssp_top.sv]
// Buffered synchronous serial port with Wishbone register access
//
// The implementer's own choices: the address map and register access over Wishbone.
module bssp_top #(
  parameter int LS_HALF = bssp_pkg::LS_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic so_o,
  input wire logic si_i,
  // Word count reached
  output logic irq_o
);
  bssp_pkg::bssp_state_t state;
  logic run, abort, tap_sel, low_speed;
  logic [2:0] mode, sck_sel, buf_cnt, idx, bitn;
  logic [1:0] wait_sel;
  logic start_req, mode_chg, written, unread, dummy, sck_prev;
  logic [15:0] hcnt, half;
  logic [7:0] gcnt, gap_len, tx_sh, rx_sh, rx_word;
  logic [7:0] buf_q [8];

  // Bus decode
  logic req, wr, buf_hit, wr_buf, rd_buf;
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i & sel_i[0];
  assign buf_hit = adr_i[7:5] == bssp_pkg::BUF_PAGE;
  assign wr_buf = wr & buf_hit;
  assign rd_buf = req & ~we_i & buf_hit;

  // Mode decode
  logic is_tx, is_rx, four, ext, internal;
  logic [2:0] last_bit;
  assign four = mode == bssp_pkg::MODE_TX4 || mode == bssp_pkg::MODE_RX4;
  assign is_tx = mode == bssp_pkg::MODE_TX8 || mode == bssp_pkg::MODE_TX4
      || mode == bssp_pkg::MODE_TRX8;
  assign is_rx = mode == bssp_pkg::MODE_TRX8 || mode == bssp_pkg::MODE_RX8
      || mode == bssp_pkg::MODE_RX4;
  assign last_bit = four ? bssp_pkg::LAST_BIT4 : bssp_pkg::LAST_BIT8;
  assign ext = sck_sel == bssp_pkg::SCK_EXT;
  assign internal = ~ext;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req & ~we_i) begin
      dat_o <= 32'h0;
      if (buf_hit) begin
        dat_o[7:0] <= buf_q[adr_i[4:2]];
      end else if (adr_i == bssp_pkg::OFS_STATUS) begin
        dat_o[bssp_pkg::ST_XFER] <= state != bssp_pkg::ST_IDLE;
        dat_o[bssp_pkg::ST_SHIFT] <= state == bssp_pkg::ST_RUN;
      end else if (adr_i == bssp_pkg::OFS_OPTION) begin
        dat_o[bssp_pkg::OPT_TAP] <= tap_sel;
        dat_o[bssp_pkg::OPT_LOW] <= low_speed;
      end
    end
  end

  // First control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'b0;
      abort <= 1'b0;
      mode <= bssp_pkg::MODE_RST;
      sck_sel <= bssp_pkg::SCK_RST;
      start_req <= 1'b0;
      mode_chg <= 1'b0;
    end else begin
      abort <= 1'b0;
      start_req <= 1'b0;
      mode_chg <= 1'b0;
      if (wr && adr_i == bssp_pkg::OFS_CTRL1) begin
        run <= dat_i[bssp_pkg::C1_RUN];
        abort <= dat_i[bssp_pkg::C1_ABORT];
        mode <= dat_i[bssp_pkg::C1_MODE +: 3];
        sck_sel <= dat_i[bssp_pkg::C1_SCK +: 3];
        start_req <= dat_i[bssp_pkg::C1_RUN];
        mode_chg <= dat_i[bssp_pkg::C1_MODE +: 3] != mode;
      end
    end
  end

  // Second control and option registers; count taken in any state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_sel <= 2'h0;
      buf_cnt <= 3'h0;
      tap_sel <= 1'b0;
      low_speed <= 1'b0;
    end else if (wr && adr_i == bssp_pkg::OFS_CTRL2) begin
      wait_sel <= dat_i[bssp_pkg::C2_WAIT +: 2];
      buf_cnt <= dat_i[bssp_pkg::C2_COUNT +: 3];
    end else if (wr && adr_i == bssp_pkg::OFS_OPTION) begin
      tap_sel <= dat_i[bssp_pkg::OPT_TAP];
      low_speed <= dat_i[bssp_pkg::OPT_LOW];
    end
  end

  // Half period of the internal serial clock
  always_comb begin
    half = 16'h0;
    case (sck_sel)
      bssp_pkg::SCK_SLOW: begin
        half = (tap_sel | low_speed) ? 16'(LS_HALF)
            : bssp_pkg::SLOW_HALF_CYC;
      end
      bssp_pkg::SCK_UNUSED, bssp_pkg::SCK_EXT: begin
        half = 16'h0;
      end
      default: begin
        half = 16'h1 << (4'h8 - {1'b0, sck_sel});
      end
    endcase
  end

  always_comb begin
    gap_len = 8'h0;
    if (internal && (mode == bssp_pkg::MODE_RX8
        || mode == bssp_pkg::MODE_TRX8)) begin
      case (wait_sel)
        2'h1: gap_len = bssp_pkg::GAP_W1;
        2'h2: gap_len = bssp_pkg::GAP_W2;
        2'h3: gap_len = bssp_pkg::GAP_W3;
        default: gap_len = 8'h0;
      endcase
    end
  end

  // Shift events
  logic tick, fall_ev, rise_ev, active, word_end, burst_end;
  logic ext_reject, store, wait_ok;
  logic gap_tick;
  assign active = state == bssp_pkg::ST_RUN || state == bssp_pkg::ST_WAIT;
  // Gap is timed in serial half periods, clock pin held high
  assign gap_tick = state == bssp_pkg::ST_GAP && hcnt == half - 16'h1;
  assign tick = internal && state == bssp_pkg::ST_RUN && hcnt == half - 16'h1;
  assign fall_ev = ext ? active & sck_prev & ~sck_i : tick & sck_o;
  assign rise_ev = ext ? active & ~sck_prev & sck_i : tick & ~sck_o;
  assign word_end = state == bssp_pkg::ST_RUN && rise_ev && bitn == last_bit;
  assign burst_end = word_end && idx == buf_cnt;
  assign ext_reject = word_end & ext & is_rx & unread;
  assign store = word_end & is_rx & ~ext_reject & ~abort;
  assign wait_ok = ~(is_tx & ~written) & ~(is_rx & unread);

  always_comb begin
    rx_word = rx_sh;
    rx_word[bitn] = si_i;
    if (four) begin
      rx_word[7:4] = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= sck_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tick || gap_tick || (state != bssp_pkg::ST_RUN
        && state != bssp_pkg::ST_GAP)) begin
      hcnt <= 16'h0;
    end else begin
      hcnt <= hcnt + 16'h1;
    end
  end

  // Clock pin idles high, so every start opens high
  always_ff @(posedge clk_i) begin
    if (rst_i || state != bssp_pkg::ST_RUN) begin
      sck_o <= 1'b1;
    end else if (tick) begin
      sck_o <= ~sck_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_oe_o <= 1'b0;
    end else begin
      sck_oe_o <= internal;
    end
  end

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= bssp_pkg::ST_IDLE;
      idx <= 3'h0;
      bitn <= 3'h0;
      gcnt <= 8'h0;
      dummy <= 1'b0;
    end else if (abort) begin
      state <= bssp_pkg::ST_IDLE;
    end else begin
      case (state)
        bssp_pkg::ST_IDLE: begin
          if (start_req && sck_sel != bssp_pkg::SCK_UNUSED) begin
            state <= bssp_pkg::ST_RUN;
            idx <= 3'h0;
            bitn <= 3'h0;
            dummy <= 1'b0;
          end
        end
        bssp_pkg::ST_RUN: begin
          if (rise_ev) begin
            bitn <= (bitn == last_bit) ? 3'h0 : bitn + 3'h1;
          end
          if (word_end) begin
            gcnt <= 8'h0;
            if (ext_reject || !run || dummy) begin
              state <= bssp_pkg::ST_IDLE;
            end else if (burst_end) begin
              idx <= 3'h0;
              state <= (internal || is_tx) ? bssp_pkg::ST_WAIT
                  : bssp_pkg::ST_RUN;
            end else begin
              idx <= idx + 3'h1;
              state <= (gap_len != 8'h0) ? bssp_pkg::ST_GAP
                  : bssp_pkg::ST_RUN;
            end
          end
        end
        bssp_pkg::ST_GAP: begin
          if (gap_tick) begin
            gcnt <= gcnt + 8'h1;
            if (gcnt == gap_len - 8'h1) begin
              state <= bssp_pkg::ST_RUN;
            end
          end
        end
        bssp_pkg::ST_WAIT: begin
          if (!run) begin
            state <= bssp_pkg::ST_IDLE;
          end else if (wait_ok) begin
            state <= bssp_pkg::ST_RUN;
          end else if (fall_ev) begin
            state <= bssp_pkg::ST_RUN;
            dummy <= 1'b1;
          end
        end
        default: begin
          state <= bssp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Transmit side: word latched as its first bit leaves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      so_o <= 1'b1;
      tx_sh <= 8'h0;
    end else if (fall_ev && is_tx) begin
      if (bitn == 3'h0) begin
        tx_sh <= buf_q[idx];
        so_o <= buf_q[idx][0];
      end else begin
        so_o <= tx_sh[bitn];
      end
    end
  end

  // Receive shifter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh <= 8'h0;
    end else if (state == bssp_pkg::ST_RUN && rise_ev && is_rx) begin
      rx_sh[bitn] <= si_i;
    end
  end

  // Software service flags; a set beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      written <= 1'b0;
      unread <= 1'b0;
    end else begin
      if (wr_buf) begin
        written <= 1'b1;
      end else if (fall_ev && bitn == 3'h0 && idx == 3'h0) begin
        written <= 1'b0;
      end
      if (burst_end && is_rx && !ext_reject && !abort) begin
        unread <= 1'b1;
      end else if (rd_buf || (start_req && state == bssp_pkg::ST_IDLE)) begin
        unread <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= burst_end & ~ext_reject & ~abort;
    end
  end

  // Data buffer entries
  for (genvar e = 0; e < 8; e++) begin : g_buf
    always_ff @(posedge clk_i) begin
      if (rst_i || mode_chg) begin
        buf_q[e] <= 8'h0;
      end else if (wr_buf && adr_i[4:2] == 3'(e)) begin
        buf_q[e] <= dat_i[7:0];
      end else if (store && idx == 3'(e)) begin
        buf_q[e] <= rx_word;
      end
    end
  end

  // Checks
  logic tx_bit0;
  assign tx_bit0 = buf_q[idx][0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_abort_stop;
    abort |=> state == bssp_pkg::ST_IDLE && !abort;
  endproperty
  a_abort_stop: assert property (p_abort_stop)
    else $error("abort did not stop the transfer");

  property p_start_high;
    (state == bssp_pkg::ST_IDLE && start_req && internal
      && sck_sel != bssp_pkg::SCK_UNUSED && !abort) |=> sck_o ##1 sck_o;
  endproperty
  a_start_high: assert property (p_start_high)
    else $error("serial clock not high at start");

  property p_lsb_first;
    (fall_ev && is_tx && bitn == 3'h0) |=> so_o == $past(tx_bit0);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("first bit out is not the lsb");

  property p_irq_count;
    irq_o |-> $past(idx) == $past(buf_cnt) && $past(word_end);
  endproperty
  a_irq_count: assert property (p_irq_count)
    else $error("interrupt before word count reached");

  property p_ext_reject;
    ext_reject |=> state == bssp_pkg::ST_IDLE && !irq_o;
  endproperty
  a_ext_reject: assert property (p_ext_reject)
    else $error("external receive not cancelled");

  property p_wait_clock;
    (state == bssp_pkg::ST_WAIT && internal) |-> sck_o && hcnt == 16'h0;
  endproperty
  a_wait_clock: assert property (p_wait_clock)
    else $error("serial clock runs during wait");

  property p_run_clear;
    (word_end && !run && !abort) |=> state == bssp_pkg::ST_IDLE;
  endproperty
  a_run_clear: assert property (p_run_clear)
    else $error("run clear did not end after the word");

  property p_gap;
    (word_end && !burst_end && run && !dummy && !abort && gap_len != 8'h0)
      |=> state == bssp_pkg::ST_GAP [*2];
  endproperty
  a_gap: assert property (p_gap)
    else $error("inter-word gap missing");

  property p_nibble;
    (store && four && idx == 3'h0) |=> buf_q[0][7:4] == 4'h0;
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("upper nibble not zero in 4-bit receive");

  property p_ack;
    ack_o |=> !ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack held for two cycles");

  c_burst: cover property (irq_o);
  c_wait: cover property (state == bssp_pkg::ST_WAIT
      ##1 state == bssp_pkg::ST_RUN);
  c_gap: cover property (state == bssp_pkg::ST_GAP);
  c_reject: cover property (ext_reject);
  c_dummy: cover property (dummy && word_end);
endmodule : bssp_top

// [bssp_peer.sv]
// Serial peripheral model on the clock and data pins
module bssp_peer (
  // Clock
  input wire logic clk_i,
  // Serial pins
  input wire logic sck_pin_i,
  input wire logic so_i,
  output logic si_o,
  output logic sck_ext_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rx_sh;
  logic [7:0] tx_sh;
  initial begin
    rx_sh = 16'h0000;
    tx_sh = 8'h00;
    si_o = 1'b0;
    sck_ext_o = 1'b1;
  end
  // Device data taken at rising pin edge, lsb arrives first
  always @(posedge sck_pin_i) begin
    rx_sh <= {so_i, rx_sh[15:1]};
  end
  // Next bit presented at falling pin edge; vacated bits inverted
  always @(negedge sck_pin_i) begin
    si_o <= tx_sh[0];
    tx_sh <= {~tx_sh[0], tx_sh[7:1]};
  end
  task load(input logic [7:0] d);
    tx_sh = d;
    rx_sh = 16'h0000;
  endtask : load
  // Each level four clk long; pin stands still between calls
  task ext_clocks(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      sck_ext_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sck_ext_o <= 1'b1;
    end
  endtask : ext_clocks
endmodule : bssp_peer

// [testbench.sv]
// Self-checking bench of the buffered serial port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i;
  logic rst_i;
  logic cyc_i;
  logic stb_i;
  logic we_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic sck_o;
  logic sck_oe_o;
  logic so_o;
  logic si_i;
  logic irq_o;
  logic sck_ext;
  logic sck_pin;
  logic [7:0] rd;
  logic [3:0] sel_v;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  assign sck_pin = sck_oe_o ? sck_o : sck_ext;
  always #25 clk_i = ~clk_i;
  bssp_top #(.LS_HALF(20)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .so_o(so_o), .si_i(si_i), .irq_o(irq_o)
  );
  bssp_peer i_peer (
    .clk_i(clk_i), .sck_pin_i(sck_pin), .so_i(so_o), .si_o(si_i),
    .sck_ext_o(sck_ext)
  );
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask : check
  // One classic cycle; ack and read data taken at the same rising edge
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= sel_v;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    check({31'h0, irq_o}, 32'h1, "count interrupt");
    @(posedge clk_i);
  endtask : wait_irq
  task t_reset;
    wb(1'b0, 8'h08, 8'h00);
    check(32'(rd), 32'h00, "status after reset");
    wb(1'b0, 8'h14, 8'h00);
    check(32'(rd), 32'h00, "unmapped read");
    sel_v = 4'h0;
    wb(1'b1, 8'h0c, 8'h03);
    sel_v = 4'h1;
    wb(1'b0, 8'h0c, 8'h00);
    check(32'(rd), 32'h00, "write without lane ignored");
    wb(1'b1, 8'h0c, 8'h03);
    wb(1'b0, 8'h0c, 8'h00);
    check(32'(rd), 32'h03, "option bits held");
    wb(1'b1, 8'h0c, 8'h00);
    check(32'(sck_oe_o), 32'h1, "internal clock drives pin");
    $display("test reset done");
  endtask : t_reset
  task t_tx8;
    i_peer.load(8'h00);
    wb(1'b1, 8'h20, 8'ha5);
    wb(1'b1, 8'h24, 8'h3c);
    wb(1'b1, 8'h04, 8'h01);
    wb(1'b1, 8'h00, 8'h85);
    check(32'(sck_o), 32'h1, "clock high at start");
    wait_irq(2000);
    check(32'(i_peer.rx_sh), 32'h3ca5, "words sent in order");
    repeat (40) @(posedge clk_i);
    check(32'(sck_o), 32'h1, "clock stopped in wait");
    wb(1'b0, 8'h08, 8'h00);
    check(32'(rd), 32'h80, "waiting status");
    wb(1'b1, 8'h00, 8'h45);
    wb(1'b0, 8'h08, 8'h00);
    check(32'(rd), 32'h00, "abort clears active");
    wb(1'b1, 8'h00, 8'h75);
    wb(1'b0, 8'h20, 8'h00);
    check(32'(rd), 32'h00, "mode change clears buffer");
    $display("test tx8 done");
  endtask : t_tx8
  task t_rx4;
    i_peer.load(8'h9b);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'hb5);
    wait_irq(1000);
    wb(1'b0, 8'h20, 8'h00);
    check(32'(rd), 32'h0b, "nibble received");
    wb(1'b1, 8'h00, 8'h75);
    wb(1'b0, 8'h08, 8'h00);
    check(32'(rd), 32'h00, "receive aborted");
    $display("test rx4 done");
  endtask : t_rx4
  task t_rx8_ext;
    wb(1'b1, 8'h00, 8'h6f);
    check(32'(sck_oe_o), 32'h0, "external clock selected");
    wb(1'b1, 8'h00, 8'haf);
    i_peer.load(8'h5a);
    i_peer.ext_clocks(8);
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h08, 8'h00);
    check(32'(rd[7]), 32'h1, "external receive running");
    i_peer.load(8'h11);
    i_peer.ext_clocks(8);
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h08, 8'h00);
    check(32'(rd[7]), 32'h0, "unread data ends receive");
    wb(1'b0, 8'h20, 8'h00);
    check(32'(rd), 32'h5a, "first word kept");
    $display("test rx8 external done");
  endtask : t_rx8_ext
  // Full duplex, two words, one extra word time between them
  task t_trx8;
    wb(1'b1, 8'h00, 8'h64);
    wb(1'b1, 8'h20, 8'h96);
    wb(1'b1, 8'h24, 8'h4b);
    wb(1'b1, 8'h04, 8'h09);
    i_peer.load(8'hc3);
    wb(1'b1, 8'h00, 8'ha4);
    repeat (350) @(posedge clk_i);
    wb(1'b0, 8'h08, 8'h00);
    check(32'(rd), 32'h80, "clock held in word gap");
    wait_irq(1500);
    check(32'(i_peer.rx_sh), 32'h4b96, "duplex sent");
    wb(1'b0, 8'h20, 8'h00);
    check(32'(rd), 32'hc3, "first duplex word");
    wb(1'b0, 8'h24, 8'h00);
    check(32'(rd), 32'h3c, "second duplex word");
    wb(1'b1, 8'h00, 8'h64);
    $display("test trx8 done");
  endtask : t_trx8
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    clk_i = 1'b0;
    rst_i <= 1'b1;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    adr_i <= 8'h00;
    sel_i <= 4'h0;
    dat_i <= 32'h0;
    sel_v = 4'h1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_tx8();
    t_rx4();
    t_rx8_ext();
    t_trx8();
    end_sim();
  end
endmodule : testbench
